//--- hdl/auto_level_ctrl.sv
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/10ps

module auto_level_ctrl import level_ctrl_pkg::*; #(
	parameter int GATE_TIMEOUT_CYCLES = GATE_CYCLES,
	parameter int FADE_TIME_CYCLES = FADE_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire stereo_sample_t adc_in,
	input wire logic adc_valid_in,
	output stereo_sample_t adc_out,
	output logic adc_valid_out,
	output logic [5:0] pga_left_gain_out,
	output logic [5:0] pga_right_gain_out
);

	localparam int FADE_STEP = (FADE_TIME_CYCLES / GAIN_STEPS > 1) ? FADE_TIME_CYCLES / GAIN_STEPS : 1;

	typedef enum logic [1:0] {G_OPEN, G_FADING, G_CLOSED} gate_state_t;

	// ======================================================================
	// Bus slave
	logic [7:0] select_reg, target_reg, timing_reg, noise_gate_control, manual_gain;
	logic wr_pend;
	logic [15:0] wr_idx;
	logic [5:0] gain;
	logic muted;
	gate_state_t gate_st, next_gate_st;
	wire addr_ok = (haddr_in[31:18] == 14'h0000) && (haddr_in[1:0] == 2'b00);
	wire [15:0] idx = haddr_in[17:2];
	wire take = hsel_in && htrans_in[1] && hready_in;
	wire [7:0] status_val = {muted, gate_st != G_OPEN, gain};
	wire fwd = wr_pend && (wr_idx == idx);
	wire [7:0] rd_val = !addr_ok ? 8'h00 : fwd ? hwdata_in[7:0] :
		(idx == SELECT_REG_IDX) ? select_reg : (idx == TARGET_REG_IDX) ? target_reg :
		(idx == TIMING_REG_IDX) ? timing_reg : (idx == NOISE_GATE_CONTROL_IDX) ? noise_gate_control :
		(idx == MANUAL_GAIN_IDX) ? manual_gain : (idx == STATUS_REG_IDX) ? status_val : 8'h00;

	// Zero wait states: read data is fetched at the address phase, and a read that
	// follows a write to the same word takes the pending data to stay coherent.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			wr_pend <= 1'b0;
			wr_idx <= 16'h0000;
			hrdata_out <= 32'h0000_0000;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			wr_pend <= take && hwrite_in && addr_ok;
			wr_idx <= idx;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
			if (take && !hwrite_in) begin
				hrdata_out <= {24'h00_0000, rd_val};
			end
		end
	end

	// Writes land at the end of the data phase; unmapped words drop the data.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			select_reg <= REG_RESET;
			target_reg <= REG_RESET;
			timing_reg <= REG_RESET;
			noise_gate_control <= REG_RESET;
			manual_gain <= REG_RESET;
		end else if (wr_pend) begin
			if (wr_idx == SELECT_REG_IDX) select_reg <= hwdata_in[7:0];
			if (wr_idx == TARGET_REG_IDX) target_reg <= hwdata_in[7:0];
			if (wr_idx == TIMING_REG_IDX) timing_reg <= hwdata_in[7:0];
			if (wr_idx == NOISE_GATE_CONTROL_IDX) noise_gate_control <= hwdata_in[7:0];
			if (wr_idx == MANUAL_GAIN_IDX) manual_gain <= hwdata_in[7:0];
		end
	end

	// ======================================================================
	// Field decode and table lookups
	wire [2:0] sel = select_reg[SEL_LSB +: 3];
	wire loop_on = (sel == SEL_LEFT) || (sel == SEL_RIGHT) || (sel == SEL_STEREO);
	wire [5:0] ceiling = MAXG_TAB[select_reg[MAXG_LSB +: 3]];
	wire [4:0] targ_level = TARGET_TAB[target_reg[TARG_LSB +: 4]];
	wire [15:0] attack_len = ATTACK_TAB[target_reg[ATCK_LSB +: 4]];
	wire [15:0] hold_len = HOLD_TAB[timing_reg[HOLD_LSB +: 4]];
	wire [15:0] decay_len = DECAY_TAB[timing_reg[DECAY_LSB +: 4]];
	wire [5:0] gate_thr = {1'b0, noise_gate_control[THR_LSB +: 5]};
	wire gate_on = loop_on && noise_gate_control[GEN_BIT];
	wire [1:0] gate_type = noise_gate_control[GTYPE_LSB +: 2];

	// ======================================================================
	// Level detection from the ADC samples
	logic [4:0] left_level, right_level;

	level_meter #(.WIDTH(24)) left_meter (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.valid_in(adc_valid_in),
		.sample_in(adc_in.left),
		.level_out(left_level)
	);

	level_meter #(.WIDTH(24)) right_meter (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.valid_in(adc_valid_in),
		.sample_in(adc_in.right),
		.level_out(right_level)
	);

	// Stereo follows the louder channel so neither side can clip unseen.
	wire [4:0] louder = (left_level > right_level) ? left_level : right_level;
	wire [4:0] det_level = (sel == SEL_STEREO) ? louder :
		(sel == SEL_RIGHT) ? right_level : left_level;
	wire over_target = det_level > targ_level;
	wire under_target = det_level < targ_level;
	wire below_thr = {1'b0, det_level} < gate_thr;
	wire exit_thr = {1'b0, det_level} >= gate_thr + HYST_STEPS;

	// ======================================================================
	// Attack, hold and decay timing, counted in samples
	logic [15:0] hold_cnt, step_cnt;
	logic [23:0] below_cnt;
	logic [23:0] fade_cnt;
	logic [5:0] next_gain;
	wire hold_done = hold_cnt >= hold_len;
	wire gain_moved = next_gain != gain;
	wire fade_tick = fade_cnt == 24'(FADE_STEP - 1);

	// Hold restarts whenever the level is not below target, which keeps a slow
	// sine from modulating the gain on every trough.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			hold_cnt <= 16'h0000;
			step_cnt <= 16'h0000;
		end else begin
			if (!loop_on || !under_target) hold_cnt <= 16'h0000;
			else if (adc_valid_in && !hold_done) hold_cnt <= hold_cnt + 16'h0001;
			if (gain_moved) step_cnt <= 16'h0000;
			else if (adc_valid_in && step_cnt != 16'hFFFF) step_cnt <= step_cnt + 16'h0001;
		end
	end

	// Gain stepping; the ceiling clamp comes first so a lowered limit bites at once.
	always_comb begin
		next_gain = gain;
		if (!loop_on) begin
			next_gain = manual_gain[5:0];
		end else if (gain > ceiling) begin
			next_gain = ceiling;
		end else if (gate_st == G_FADING) begin
			if (fade_tick && gain != 6'd0) next_gain = gain - 6'd1;
		end else if (gate_st == G_CLOSED && gate_type != GATE_MUTE) begin
			next_gain = gain;
		end else if (adc_valid_in) begin
			if (over_target && step_cnt >= attack_len && gain != 6'd0) begin
				next_gain = gain - 6'd1;
			end else if (under_target && hold_done && step_cnt >= decay_len && gain < ceiling) begin
				next_gain = gain + 6'd1;
			end
		end
	end

	// ======================================================================
	// Noise gate
	always_comb begin
		next_gate_st = gate_st;
		unique case (gate_st)
			G_OPEN: begin
				if (gate_on && below_thr && below_cnt == 24'(GATE_TIMEOUT_CYCLES - 1)) begin
					next_gate_st = gate_type[1] ? G_FADING : G_CLOSED;
				end
			end
			G_FADING: begin
				if (!gate_on || exit_thr) next_gate_st = G_OPEN;
				else if (gain == 6'd0) next_gate_st = G_CLOSED;
			end
			G_CLOSED: begin
				if (!gate_on || exit_thr) next_gate_st = G_OPEN;
			end
		endcase
	end

	wire next_muted = gate_on && ((next_gate_st == G_CLOSED && gate_type == GATE_MUTE) ||
		(next_gate_st == G_CLOSED && gate_type == GATE_FADE_MUTE));

	// The timeout counts clock cycles, not samples, so it holds at any rate.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			gate_st <= G_OPEN;
			below_cnt <= 24'h00_0000;
			fade_cnt <= 24'h00_0000;
			gain <= 6'd0;
			muted <= 1'b0;
		end else begin
			gate_st <= next_gate_st;
			gain <= next_gain;
			muted <= next_muted;
			if (!gate_on || !below_thr || gate_st != G_OPEN) below_cnt <= 24'h00_0000;
			else if (below_cnt != 24'(GATE_TIMEOUT_CYCLES - 1)) below_cnt <= below_cnt + 24'h00_0001;
			if (gate_st != G_FADING || fade_tick) fade_cnt <= 24'h00_0000;
			else fade_cnt <= fade_cnt + 24'h00_0001;
		end
	end

	// ======================================================================
	// Outputs: the loop gain goes only to the channels the select names.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			adc_out <= '0;
			adc_valid_out <= 1'b0;
			pga_left_gain_out <= 6'd0;
			pga_right_gain_out <= 6'd0;
		end else begin
			adc_valid_out <= adc_valid_in;
			if (adc_valid_in) adc_out <= next_muted ? '0 : adc_in;
			pga_left_gain_out <= (sel == SEL_RIGHT) ? manual_gain[5:0] : next_gain;
			pga_right_gain_out <= (sel == SEL_LEFT) ? manual_gain[5:0] : next_gain;
		end
	end

	// ======================================================================
	// Checks
	property p_ceiling;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		loop_on && $past(loop_on) && $stable(select_reg) |-> gain <= ceiling;
	endproperty
	a_ceiling: assert property (p_ceiling) else $error("gain above ceiling");

	property p_off_manual;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		!loop_on |=> pga_left_gain_out == $past(manual_gain[5:0]) && gate_st == G_OPEN;
	endproperty
	a_off_manual: assert property (p_off_manual) else $error("disabled loop moved gain");

	property p_hold_freeze;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		(gate_st == G_CLOSED && gate_type == GATE_HOLD && gain <= ceiling && loop_on) ##1
		(gate_st == G_CLOSED && gate_type == GATE_HOLD && loop_on) |-> $stable(gain);
	endproperty
	a_hold_freeze: assert property (p_hold_freeze) else $error("gain moved while held");

	property p_mute_now;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		$rose(gate_st == G_CLOSED) && gate_type == GATE_MUTE && $stable(noise_gate_control) |-> muted;
	endproperty
	a_mute_now: assert property (p_mute_now) else $error("type 01 not muted on gating");

	property p_fade_unmuted;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		gate_type == 2'b10 && $stable(noise_gate_control) |-> !muted; // The mute flag lags a type change by one edge.
	endproperty
	a_fade_unmuted: assert property (p_fade_unmuted) else $error("type 10 muted");

	property p_timeout;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		$past(gate_st) == G_OPEN && gate_st != G_OPEN |-> $past(below_cnt) == 24'(GATE_TIMEOUT_CYCLES - 1);
	endproperty
	a_timeout: assert property (p_timeout) else $error("gate engaged before timeout");

	property p_hyst;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		$past(gate_st) != G_OPEN && gate_st == G_OPEN |-> $past(exit_thr) || !$past(gate_on);
	endproperty
	a_hyst: assert property (p_hyst) else $error("gate left below exit level");

	property p_rise_after_hold;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		$past(loop_on) && loop_on && gain > $past(gain) |-> $past(hold_done) && $past(under_target);
	endproperty
	a_rise_after_hold: assert property (p_rise_after_hold) else $error("gain rose before hold");

	property p_fall_cause;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		$past(loop_on) && loop_on && gain < $past(gain) |->
		$past(over_target) || $past(gate_st) == G_FADING || $past(gain) > $past(ceiling);
	endproperty
	a_fall_cause: assert property (p_fall_cause) else $error("gain fell without cause");

	property p_stereo_max;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		sel == SEL_STEREO |-> det_level >= left_level && det_level >= right_level;
	endproperty
	a_stereo_max: assert property (p_stereo_max) else $error("stereo level not the max");

	c_attack: cover property (@(posedge core_clk_in) disable iff (sys_rst_in) loop_on && gain < $past(gain));
	c_gate_close: cover property (@(posedge core_clk_in) disable iff (sys_rst_in) $rose(gate_st == G_CLOSED));
	c_fade_mute: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
		gate_type == GATE_FADE_MUTE && $rose(muted));
	c_reopen: cover property (@(posedge core_clk_in) disable iff (sys_rst_in) $rose(gate_st == G_OPEN));

endmodule : auto_level_ctrl

//--- hdl/level_ctrl_pkg.sv
package level_ctrl_pkg;

	// ======================================================================
	// Register indices; the byte address on the bus is four times the index.
	localparam logic [15:0] SELECT_REG_IDX = 16'h4011;
	localparam logic [15:0] TARGET_REG_IDX = 16'h4012;
	localparam logic [15:0] TIMING_REG_IDX = 16'h4013;
	localparam logic [15:0] NOISE_GATE_CONTROL_IDX = 16'h4014;
	localparam logic [15:0] MANUAL_GAIN_IDX = 16'h4030;
	localparam logic [15:0] STATUS_REG_IDX = 16'h4031;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ======================================================================
	// Field positions inside the 8-bit registers.
	localparam int SEL_LSB = 0;
	localparam int MAXG_LSB = 3;
	localparam int TARG_LSB = 0;
	localparam int ATCK_LSB = 4;
	localparam int HOLD_LSB = 0;
	localparam int DECAY_LSB = 4;
	localparam int THR_LSB = 0;
	localparam int GEN_BIT = 5;
	localparam int GTYPE_LSB = 6;

	// Operating modes of the select field, then the gate types; every other select code leaves the loop off.
	localparam logic [2:0] SEL_LEFT = 3'h1;
	localparam logic [2:0] SEL_RIGHT = 3'h2;
	localparam logic [2:0] SEL_STEREO = 3'h3;
	localparam logic [1:0] GATE_HOLD = 2'h0;
	localparam logic [1:0] GATE_MUTE = 2'h1;
	localparam logic [1:0] GATE_FADE_MUTE = 2'h3;

	// ======================================================================
	// Timing; levels are in 6 dB steps, so one step is the exit hysteresis.
	localparam int CLK_HZ = 40_000_000;
	localparam int GATE_TIMEOUT_MS = 250;
	localparam int GATE_CYCLES = GATE_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int FADE_MS = 100;
	localparam int FADE_CYCLES = FADE_MS * (CLK_HZ / 1000);
	localparam int GAIN_STEPS = 64;
	localparam logic [5:0] HYST_STEPS = 6'h01;

	// ======================================================================
	// Build-time code tables: sample counts per gain step and for hold, levels, ceilings.
	localparam logic [15:0] ATTACK_TAB [0:15] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
		16'h0010, 16'h0020, 16'h0040, 16'h0080, 16'h0100, 16'h0200, 16'h0400, 16'h0800,
		16'h1000, 16'h2000, 16'h4000, 16'h8000};
	localparam logic [15:0] DECAY_TAB [0:15] = '{16'h0008, 16'h0010, 16'h0020, 16'h0040,
		16'h0080, 16'h0100, 16'h0200, 16'h0400, 16'h0800, 16'h1000, 16'h2000, 16'h4000,
		16'h6000, 16'h8000, 16'hC000, 16'hFFFF};
	localparam logic [15:0] HOLD_TAB [0:15] = '{16'h0000, 16'h0080, 16'h0100, 16'h0200,
		16'h0400, 16'h0800, 16'h1000, 16'h2000, 16'h3000, 16'h4000, 16'h6000, 16'h8000,
		16'hA000, 16'hC000, 16'hE000, 16'hFFFF};
	localparam logic [4:0] TARGET_TAB [0:15] = '{5'd8, 5'd9, 5'd10, 5'd11, 5'd12, 5'd13,
		5'd14, 5'd15, 5'd16, 5'd17, 5'd18, 5'd19, 5'd20, 5'd21, 5'd22, 5'd23};
	localparam logic [5:0] MAXG_TAB [0:7] = '{6'd14, 6'd21, 6'd28, 6'd35, 6'd42, 6'd49,
		6'd56, 6'd63};

	// ======================================================================
	// One stereo ADC sample pair.
	typedef struct packed {
		logic [23:0] left;
		logic [23:0] right;
	} stereo_sample_t;

endpackage : level_ctrl_pkg

//--- hdl/level_meter.sv
`timescale 1ns/10ps

// ==========================================================================
// Log-domain level of one channel: index of the top magnitude bit plus one, 6 dB each.
module level_meter #(
	parameter int WIDTH = 24
) (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic valid_in,
	input wire logic [WIDTH-1:0] sample_in,
	output logic [4:0] level_out
);

	logic [WIDTH-1:0] mag;
	logic [4:0] next_level;

	// One's complement keeps full-scale negative in range without a carry chain.
	assign mag = sample_in[WIDTH-1] ? ~sample_in : sample_in;

	// Leading-one search; zero input reads as level zero.
	always_comb begin
		next_level = 5'd0;
		for (int i = 0; i < WIDTH; i++) begin
			if (mag[i]) begin
				next_level = 5'(i + 1);
			end
		end
	end

	// The level only moves on a fresh sample.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			level_out <= 5'd0;
		end else if (valid_in) begin
			level_out <= next_level;
		end
	end

endmodule : level_meter

//--- tb/pga_adc_model.sv
`timescale 1ns/10ps

// ==========================================================================
// Far side: analog gain stage and ADC, one sample pair every fourth cycle.
module pga_adc_model import level_ctrl_pkg::*; (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic [4:0] left_level_in,
	input wire logic [4:0] right_level_in,
	input wire logic [5:0] pga_left_gain_in,
	input wire logic [5:0] pga_right_gain_in,
	output stereo_sample_t adc_out,
	output logic adc_valid_out
);
	logic [1:0] phase;

	// The gain is not fed back into the samples, so the loop is pushed to its limits.
	// Off the valid cycle the bus inverts on every edge, so it alternates between the inverse of the last pair and the pair itself.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			phase <= 2'd0;
			adc_valid_out <= 1'b0;
			adc_out <= '0;
		end else begin
			phase <= phase + 2'd1;
			adc_valid_out <= (phase == 2'd3);
			if (phase == 2'd3) begin
				adc_out.left <= (left_level_in == 5'd0) ? 24'h0 : 24'h1 << (left_level_in - 5'd1);
				adc_out.right <= (right_level_in == 5'd0) ? 24'h0 : 24'h1 << (right_level_in - 5'd1);
			end else begin
				adc_out <= ~adc_out;
			end
		end
	end
endmodule : pga_adc_model

//--- tb/auto_level_ctrl_bench.sv
`timescale 1ns/10ps

// ==========================================================================
// Self-checking bench: register table, then loop modes, limits and gate types.
module auto_level_ctrl_bench import level_ctrl_pkg::*; ();
	localparam int GATE_T = 200;
	localparam int FADE_T = 640;
	logic core_clk_in, sys_rst_in, hsel_in, hwrite_in, hreadyout_out, hresp_out, adc_valid_in, adc_valid_out;
	logic [1:0] htrans_in;
	logic [2:0] hsize_in;
	logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
	logic [4:0] lvl_l, lvl_r;
	logic [5:0] pga_left_gain_out, pga_right_gain_out, g1;
	stereo_sample_t adc_in, adc_out;
	logic [47:0] s;
	int err_count, cmp_count;
	logic [15:0] t_idx [7] = '{16'h4012, 16'h4013, 16'h4014, 16'h4030, 16'h0010, 16'h4012, 16'h4013};
	logic [31:0] t_wd [7] = '{32'h0000_00A5, 32'h0000_005A, 32'h0000_00FF, 32'h0000_0005, 32'h0000_00FF,
		32'h0000_0F00, 32'hFFFF_FF00};
	logic [31:0] t_rd [7] = '{32'h0000_00A5, 32'h0000_005A, 32'h0000_00FF, 32'h0000_0005, 32'h0000_0000,
		32'h0000_0000, 32'h0000_0000};
	logic [7:0] m_sel [3] = '{8'h01, 8'h02, 8'h0B};
	logic [5:0] m_l [3] = '{6'd14, 6'd5, 6'd21};
	logic [5:0] m_r [3] = '{6'd5, 6'd14, 6'd21};

	auto_level_ctrl #(.GATE_TIMEOUT_CYCLES(GATE_T), .FADE_TIME_CYCLES(FADE_T)) dut (.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
		.hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
		.hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .adc_in(adc_in),
		.adc_valid_in(adc_valid_in), .adc_out(adc_out), .adc_valid_out(adc_valid_out),
		.pga_left_gain_out(pga_left_gain_out), .pga_right_gain_out(pga_right_gain_out));

	pga_adc_model far_side (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .left_level_in(lvl_l),
		.right_level_in(lvl_r), .pga_left_gain_in(pga_left_gain_out), .pga_right_gain_in(pga_right_gain_out),
		.adc_out(adc_in), .adc_valid_out(adc_valid_in));

	// ======================================================================
	// Compare and report helpers.
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_gain(input logic [5:0] got, input logic [5:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: gain %0d, expected %0d", $time, got, exp);
		end
	endtask : check_gain

	task automatic check_sample(input logic [47:0] got, input logic [47:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: sample %h, expected %h", $time, got, exp);
		end
	endtask : check_sample

	task automatic tally_and_finish;
		$display("comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	// Single AHB transfer; the address phase is held until hready is seen high.
	task automatic bus_xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		hsel_in <= 1'b1;
		haddr_in <= {14'h0, idx, 2'b00};
		hwrite_in <= wr;
		htrans_in <= 2'b10;
		do @(posedge core_clk_in); while (hreadyout_out !== 1'b1);
		htrans_in <= 2'b00;
		hwdata_in <= wd;
		do @(posedge core_clk_in); while (hreadyout_out !== 1'b1);
		rd = hrdata_out;
	endtask : bus_xfer

	// Waits for the next sample pair; the watchdog bounds the wait.
	task automatic grab;
		do @(posedge core_clk_in); while (adc_valid_out !== 1'b1);
		s = adc_out;
	endtask : grab

	function automatic logic [47:0] pair(input logic [4:0] l);
		logic [23:0] v;
		v = (l == 5'd0) ? 24'h0 : 24'h1 << (l - 5'd1);
		return {v, v};
	endfunction : pair

	// Clock generation.
	initial begin
		core_clk_in = 1'b0;
		forever #12.5 core_clk_in = ~core_clk_in;
	end

	// The run is about eleven thousand cycles, so thirty thousand means a hang.
	initial begin
		repeat (30000) @(posedge core_clk_in);
		err_count++;
		$display("wrong value at %0t: run did not finish", $time);
		tally_and_finish();
	end

	// ======================================================================
	// Main sequence.
	initial begin
		{sys_rst_in, hsel_in, hwrite_in, htrans_in, haddr_in, hwdata_in} = {1'b1, 68'h0};
		hsize_in = 3'b010;
		lvl_l = 5'd2;
		lvl_r = 5'd2;
		err_count = 0;
		cmp_count = 0;
		repeat (20) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		@(posedge core_clk_in);
		check_word({17'h0, hreadyout_out, hresp_out, pga_left_gain_out, pga_right_gain_out, adc_valid_out},
			32'h0000_4000);
		for (int i = 0; i < 4; i++) begin
			bus_xfer(1'b0, 16'h4011 + 16'(i), 32'h0);
			check_word(rd, 32'h0);
		end
		$display("test reset finished");
		// Unmapped index, low-byte use and the gate register all go through one row loop.
		for (int i = 0; i < 7; i++) begin
			bus_xfer(1'b1, t_idx[i], t_wd[i]);
			bus_xfer(1'b0, t_idx[i], 32'h0);
			check_word(rd, t_rd[i]);
		end
		$display("test registers finished");
		// Moderate attack and slower decay keep the loop from pumping; the codes suit this short run.
		bus_xfer(1'b1, 16'h4012, 32'h0000_0020);
		bus_xfer(1'b1, 16'h4013, 32'h0000_0010);
		// Loop off: an unused select code leaves the manual gain and does no gating.
		bus_xfer(1'b1, 16'h4011, 32'h0000_0007);
		bus_xfer(1'b1, 16'h4014, 32'h0000_0066);
		repeat (400) @(posedge core_clk_in);
		check_gain(pga_left_gain_out, 6'd5);
		check_gain(pga_right_gain_out, 6'd5);
		grab();
		check_sample(s, pair(5'd2));
		$display("test loop_off finished");
		// Each mode drives its own channels up to the ceiling; the other keeps the manual gain.
		bus_xfer(1'b1, 16'h4014, 32'h0);
		for (int m = 0; m < 3; m++) begin
			bus_xfer(1'b1, 16'h4011, {24'h0, m_sel[m]});
			repeat (1000) @(posedge core_clk_in);
			check_gain(pga_left_gain_out, m_l[m]);
			check_gain(pga_right_gain_out, m_r[m]);
		end
		$display("test modes finished");
		// Only the left channel is loud, so a loop that took the smaller level would not attack.
		lvl_l <= 5'd20;
		repeat (600) @(posedge core_clk_in);
		check_gain(pga_left_gain_out, 6'd0);
		check_gain(pga_right_gain_out, 6'd0);
		$display("test attack finished");
		// Mute type with hysteresis: level at the threshold keeps the gate shut, one step above opens it.
		lvl_l <= 5'd2;
		bus_xfer(1'b1, 16'h4014, 32'h0000_0066);
		repeat (GATE_T + 100) @(posedge core_clk_in);
		grab();
		check_sample(s, 48'h0);
		lvl_l <= 5'd6;
		lvl_r <= 5'd6;
		repeat (100) @(posedge core_clk_in);
		grab();
		check_sample(s, 48'h0);
		lvl_l <= 5'd7;
		lvl_r <= 5'd7;
		repeat (100) @(posedge core_clk_in);
		grab();
		check_sample(s, pair(5'd7));
		$display("test mute finished");
		// Hold type: gain climbs until the gate shuts, then stays put well short of the ceiling.
		lvl_l <= 5'd20;
		lvl_r <= 5'd20;
		repeat (200) @(posedge core_clk_in);
		lvl_l <= 5'd2;
		lvl_r <= 5'd2;
		bus_xfer(1'b1, 16'h4014, 32'h0000_0026);
		repeat (400) @(posedge core_clk_in);
		g1 = pga_left_gain_out;
		repeat (400) @(posedge core_clk_in);
		check_gain(pga_left_gain_out, g1);
		check_word({31'h0, g1 < 6'd21}, 32'h1);
		$display("test hold finished");
		// Fade types: gain must reach the minimum; only the last type also mutes.
		for (int t = 2; t < 4; t++) begin
			bus_xfer(1'b1, 16'h4014, 32'h0);
			repeat (1000) @(posedge core_clk_in);
			bus_xfer(1'b1, 16'h4014, 32'h0000_0026 | (t << 6));
			repeat (GATE_T + FADE_T + 200) @(posedge core_clk_in);
			check_gain(pga_left_gain_out, 6'd0);
			bus_xfer(1'b0, 16'h4031, 32'h0);
			check_word(rd, (t == 3) ? 32'h0000_00C0 : 32'h0000_0040);
			grab();
			check_sample(s, (t == 3) ? 48'h0 : pair(5'd2));
		end
		$display("test fade finished");
		// Hold time: after a loud spell the gain may not climb until the level has stayed low long enough.
		bus_xfer(1'b1, 16'h4013, 32'h0000_0011);
		bus_xfer(1'b1, 16'h4014, 32'h0);
		lvl_l <= 5'd20;
		lvl_r <= 5'd20;
		repeat (100) @(posedge core_clk_in);
		lvl_l <= 5'd2;
		lvl_r <= 5'd2;
		repeat (400) @(posedge core_clk_in);
		check_gain(pga_left_gain_out, 6'd0);
		repeat (400) @(posedge core_clk_in);
		check_word({31'h0, pga_left_gain_out != 6'd0}, 32'h1);
		$display("test hold_time finished");
		tally_and_finish();
	end
endmodule : auto_level_ctrl_bench
